// file: src/ecl_defs.svh
// Purpose: Constants for the hypervisor leaf engine (leaf codes, result codes, page types, masks, offsets).
// Assumes: Included by bare name; definitions only.
// Notes:   Page-type encodings and the conflict code value are local choices.
`ifndef ECL_DEFS_SVH
`define ECL_DEFS_SVH

// ----------------------------------------------------------------------------
// Leaf selectors and result codes
// ----------------------------------------------------------------------------
`define ECL_LEAF_INC 64'h0000_0000_0000_0001
`define ECL_LEAF_SETCTX 64'h0000_0000_0000_0002
`define ECL_RES_OK 64'h0000_0000_0000_0000
`define ECL_RES_CONFLICT 64'h0000_0000_0000_0001

// ----------------------------------------------------------------------------
// Page types
// ----------------------------------------------------------------------------
`define ECL_PT_CTRL 3'h0
`define ECL_THREAD_CONTROL_PAGE_TYPE 3'h1
`define ECL_REGULAR_PAGE_TYPE 3'h2
`define ECL_TRIMMED_PAGE_TYPE 3'h4
`define ECL_FIRST_SHADOW_STACK_TYPE 3'h5
`define ECL_REST_SHADOW_STACK_TYPE 3'h6

// ----------------------------------------------------------------------------
// Alignment masks, address shape, kernel privilege level and field offsets
// ----------------------------------------------------------------------------
`define ECL_PAGE_MASK 64'h0000_0000_0000_0FFF
`define ECL_QWORD_MASK 64'h0000_0000_0000_0007
`define ECL_CANON_MSB 47
`define ECL_CPL_KERNEL 2'h0
`define ECL_CTX_OFFSET 32'h0000_0040
`define ECL_CNT_OFFSET 32'h0000_0048

`endif

// file: src/ecl_engine.sv
// Purpose: Executes the increment-child-count and set-context hypervisor leaves.
// Assumes: One map lookup per operand, answered combinationally; memory answers with ACK.
// Notes:   Faults leave memory, result and flags untouched; the counter increment is one locked RMW.
//
// How it works
// [RULE_01] Leaf selector 02H runs set-context on the addressed control page.
// [RULE_02] Leaf selector 01H runs the child counter increment.
// [RULE_03] Increment is only allowed at privilege level zero.
// [RULE_04] Increment target not 4K aligned raises protection fault, code zero.
// [RULE_05] Target or control operand outside protected cache raises page fault.
// [RULE_06] Busy target sets zero flag, conflict code, jumps to flag cleanup.
// [RULE_07] Target map entry with valid bit zero raises page fault.
// [RULE_08] Child types resolve to parent, control type to itself, else page fault.
// [RULE_09] Resolved parent differing from control operand address raises protection fault.
// [RULE_10] Counter increment is one locked read-modify-write.
// [RULE_11] Success clears zero flag and writes result zero.
// [RULE_12] Completion clears carry, parity, aux-carry, overflow and sign flags.
// [RULE_13] Other page operations never cause a conflict for the increment.
// [RULE_14] Protected mode: operand beyond segment limit or unusable segment faults.
// [RULE_15] 64-bit mode: non-canonical operand address raises protection fault.
// [RULE_16] Control operand not a control page raises page fault.
// [RULE_17] Caller puts control page in count register, value pointer in data.
// [RULE_18] Set-context overwrites context field with value fetched via pointer.
// [RULE_19] Creating or loading a control page sets context to its own address.
// [RULE_20] Set-context fails on any misaligned operand.
// [RULE_21] Control page read as enclave, context pointer read as non-enclave.
// [RULE_22] Context pointer not 8-byte aligned raises protection fault.
// [RULE_23] Faults leave counter, context, result and flags unchanged.
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "ecl_defs.svh"

module ecl_engine #(
   parameter int CTX_OFFSET = `ECL_CTX_OFFSET,
   parameter int CNT_OFFSET = `ECL_CNT_OFFSET
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic REQ_VALID,
   output logic REQ_READY,
   input wire ecl_pkg::ecl_req_type REQ,
   input wire ecl_pkg::ecl_map_type TARGET_MAP,
   input wire ecl_pkg::ecl_map_type CTRL_MAP,
   input wire logic INIT_VALID,
   input wire logic [63:0] INIT_PAGE,
   output logic MEM_RD,
   output logic MEM_WR,
   output logic MEM_LOCK,
   output logic MEM_ENCLAVE,
   output logic [63:0] MEM_ADDR,
   output logic [63:0] MEM_WDATA,
   input wire logic MEM_ACK,
   input wire logic [63:0] MEM_RDATA,
   output logic DONE,
   output logic [1:0] FAULT,
   output logic [63:0] FAULT_ADDR,
   output ecl_pkg::ecl_resp_type RESP
);

   // -------------------------------------------------------------------------
   // Operand checks
   // -------------------------------------------------------------------------
   function automatic logic bad_addr(input logic [63:0] a, input ecl_pkg::ecl_req_type r);
      logic canon;
      canon = (a[63:`ECL_CANON_MSB] == {(64 - `ECL_CANON_MSB){1'b0}})
         || (a[63:`ECL_CANON_MSB] == {(64 - `ECL_CANON_MSB){1'b1}});
      if (r.long_mode) begin
         bad_addr = !canon; // [RULE_15]
      end else begin
         bad_addr = !r.seg_usable || (a > r.seg_limit); // [RULE_14]
      end
   endfunction

   function automatic logic child_type(input logic [2:0] t);
      child_type = (t == `ECL_REGULAR_PAGE_TYPE) || (t == `ECL_THREAD_CONTROL_PAGE_TYPE) || (t == `ECL_TRIMMED_PAGE_TYPE)
         || (t == `ECL_FIRST_SHADOW_STACK_TYPE) || (t == `ECL_REST_SHADOW_STACK_TYPE);
   endfunction

   function automatic logic [63:0] field(input logic [63:0] page, input int off);
      field = page + 64'(off);
   endfunction

   ecl_pkg::ecl_regs_type r;
   ecl_pkg::ecl_regs_type next_r;

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb begin
      ecl_pkg::ecl_req_type q;
      logic is_inc;
      next_r = r;
      q = r.req;
      is_inc = (q.leaf == `ECL_LEAF_INC);
      next_r.done = 1'b0;
      case (r.state)
         ecl_pkg::ST_IDLE: begin
            next_r.mem_lock = 1'b0;
            if (INIT_VALID) begin
               // Default context is the control page's own address.
               next_r.mem_wr = 1'b1; // [RULE_19]
               next_r.mem_enclave = 1'b1;
               next_r.mem_addr = field(INIT_PAGE, CTX_OFFSET);
               next_r.mem_wdata = INIT_PAGE;
               next_r.state = ecl_pkg::ST_WRITE;
            end else if (REQ_VALID) begin
               next_r.req = REQ;
               next_r.fault = ecl_pkg::FLT_NONE;
               next_r.state = ecl_pkg::ST_LOOK;
            end
         end
         ecl_pkg::ST_LOOK: begin
            next_r.state = ecl_pkg::ST_FAULT;
            next_r.fault = ecl_pkg::FLT_GP;
            next_r.fault_addr = 64'h0;
            if (is_inc) begin // [RULE_02]
               // Concurrency with other page operations is ignored: only busy counts.
               if (q.cpl != `ECL_CPL_KERNEL) begin // [RULE_03]
               end else if (bad_addr(q.target, q) || bad_addr(q.ctrl, q)) begin
               end else if ((q.target & `ECL_PAGE_MASK) != 64'h0) begin // [RULE_04]
               end else if (!TARGET_MAP.in_cache) begin // [RULE_05]
                  next_r.fault = ecl_pkg::FLT_PF;
                  next_r.fault_addr = q.target;
               end else if (!CTRL_MAP.in_cache) begin // [RULE_05]
                  next_r.fault = ecl_pkg::FLT_PF;
                  next_r.fault_addr = q.ctrl;
               end else if (TARGET_MAP.busy) begin // [RULE_06] [RULE_13]
                  next_r.fault = ecl_pkg::FLT_NONE;
                  next_r.resp.zf = 1'b1;
                  next_r.resp.result = `ECL_RES_CONFLICT;
                  next_r.state = ecl_pkg::ST_DONE;
               end else if (!TARGET_MAP.valid || !(child_type(TARGET_MAP.page_type)
                  || TARGET_MAP.page_type == `ECL_PT_CTRL)) begin // [RULE_07] [RULE_08]
                  next_r.fault = ecl_pkg::FLT_PF;
                  next_r.fault_addr = q.target;
               end else if (!CTRL_MAP.valid || CTRL_MAP.page_type != `ECL_PT_CTRL) begin
                  next_r.fault = ecl_pkg::FLT_PF; // [RULE_16]
                  next_r.fault_addr = q.ctrl;
               end else begin
                  next_r.parent = child_type(TARGET_MAP.page_type) ? TARGET_MAP.parent
                     : TARGET_MAP.phys; // [RULE_08]
                  if (next_r.parent != CTRL_MAP.phys) begin // [RULE_09]
                  end else begin
                     next_r.fault = ecl_pkg::FLT_NONE;
                     next_r.mem_rd = 1'b1;
                     next_r.mem_lock = 1'b1; // [RULE_10]
                     next_r.mem_enclave = 1'b1;
                     next_r.mem_addr = field(CTRL_MAP.phys, CNT_OFFSET);
                     next_r.state = ecl_pkg::ST_READ;
                  end
               end
            end else if (q.leaf == `ECL_LEAF_SETCTX) begin // [RULE_01] [RULE_17]
               if (bad_addr(q.ctrl, q) || bad_addr(q.data, q)) begin
               end else if ((q.ctrl & `ECL_PAGE_MASK) != 64'h0) begin // [RULE_20]
               end else if (!CTRL_MAP.in_cache) begin // [RULE_05]
                  next_r.fault = ecl_pkg::FLT_PF;
                  next_r.fault_addr = q.ctrl;
               end else if ((q.data & `ECL_QWORD_MASK) != 64'h0) begin // [RULE_22]
               end else begin
                  // Fetch the new context value through the non-enclave pointer.
                  next_r.fault = ecl_pkg::FLT_NONE;
                  next_r.mem_rd = 1'b1;
                  next_r.mem_enclave = 1'b0; // [RULE_21]
                  next_r.mem_addr = q.data;
                  next_r.state = ecl_pkg::ST_READ;
               end
            end
         end
         ecl_pkg::ST_READ: begin
            if (MEM_ACK) begin
               next_r.mem_rd = 1'b0;
               next_r.value = MEM_RDATA;
               if (is_inc) begin
                  next_r.mem_wr = 1'b1;
                  next_r.mem_wdata = MEM_RDATA + 64'h1; // [RULE_10]
                  next_r.state = ecl_pkg::ST_WRITE;
               end else if (CTRL_MAP.busy) begin
                  next_r.resp.zf = 1'b1; // [RULE_06]
                  next_r.resp.result = `ECL_RES_CONFLICT;
                  next_r.state = ecl_pkg::ST_DONE;
               end else if (!CTRL_MAP.valid || CTRL_MAP.page_type != `ECL_PT_CTRL) begin
                  next_r.fault = ecl_pkg::FLT_PF; // [RULE_16]
                  next_r.fault_addr = q.ctrl;
                  next_r.state = ecl_pkg::ST_FAULT;
               end else begin
                  next_r.mem_wr = 1'b1;
                  next_r.mem_enclave = 1'b1; // [RULE_21]
                  next_r.mem_addr = field(CTRL_MAP.phys, CTX_OFFSET);
                  next_r.mem_wdata = MEM_RDATA; // [RULE_18]
                  next_r.state = ecl_pkg::ST_WRITE;
               end
            end
         end
         ecl_pkg::ST_WRITE: begin
            if (MEM_ACK) begin
               next_r.mem_wr = 1'b0;
               next_r.mem_lock = 1'b0;
               // A pending page set-up must not swallow the result of a running leaf.
               if (r.fault == ecl_pkg::FLT_NONE && r.req.leaf != 64'h0) begin
                  next_r.resp.zf = 1'b0; // [RULE_11]
                  next_r.resp.result = `ECL_RES_OK;
               end
               next_r.state = (r.req.leaf == 64'h0) ? ecl_pkg::ST_IDLE : ecl_pkg::ST_DONE;
            end
         end
         ecl_pkg::ST_DONE: begin
            next_r.resp.cf = 1'b0; // [RULE_12]
            next_r.resp.pf = 1'b0;
            next_r.resp.af = 1'b0;
            next_r.resp.of_flag = 1'b0;
            next_r.resp.sf = 1'b0;
            next_r.req.leaf = 64'h0;
            next_r.done = 1'b1;
            next_r.state = ecl_pkg::ST_IDLE;
         end
         ecl_pkg::ST_FAULT: begin
            // Nothing architectural is touched on this path.
            next_r.req.leaf = 64'h0; // [RULE_23]
            next_r.done = 1'b1;
            next_r.state = ecl_pkg::ST_IDLE;
         end
         default: begin
            next_r.state = ecl_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         r <= '0;
         r.state <= ecl_pkg::ST_IDLE;
      end else begin
         r <= next_r;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign REQ_READY = (r.state == ecl_pkg::ST_IDLE) && !INIT_VALID;
   assign MEM_RD = r.mem_rd;
   assign MEM_WR = r.mem_wr;
   assign MEM_LOCK = r.mem_lock;
   assign MEM_ENCLAVE = r.mem_enclave;
   assign MEM_ADDR = r.mem_addr;
   assign MEM_WDATA = r.mem_wdata;
   assign DONE = r.done;
   assign FAULT = (r.done) ? r.fault : ecl_pkg::FLT_NONE;
   assign FAULT_ADDR = r.fault_addr;
   assign RESP = r.resp;

endmodule // ecl_engine

// file: src/ecl_pkg.sv
// Purpose: Types shared by the hypervisor leaf engine and its bench.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes:   Only state and fault encodings live here; other numbers are in ecl_defs.svh.
package ecl_pkg;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_LOOK = 6'h02,
      ST_READ = 6'h04,
      ST_WRITE = 6'h08,
      ST_DONE = 6'h10,
      ST_FAULT = 6'h20
   } ecl_state_type;

   typedef enum logic [1:0] {
      FLT_NONE = 2'h0,
      FLT_GP = 2'h1,
      FLT_PF = 2'h2
   } ecl_fault_type;

   // Instruction request from the core.
   typedef struct packed {
      logic [63:0] leaf;
      logic [63:0] target;
      logic [63:0] ctrl;
      logic [63:0] data;
      logic [1:0] cpl;
      logic long_mode;
      logic seg_usable;
      logic [63:0] seg_limit;
   } ecl_req_type;

   // Page cache map lookup answer for one linear address.
   typedef struct packed {
      logic in_cache;
      logic valid;
      logic busy;
      logic [2:0] page_type;
      logic [63:0] phys;
      logic [63:0] parent;
   } ecl_map_type;

   // Architectural completion state.
   typedef struct packed {
      logic [63:0] result;
      logic zf;
      logic cf;
      logic pf;
      logic af;
      logic of_flag;
      logic sf;
   } ecl_resp_type;

   typedef struct packed {
      ecl_state_type state;
      ecl_req_type req;
      logic [63:0] parent;
      logic [63:0] value;
      ecl_fault_type fault;
      logic [63:0] fault_addr;
      logic mem_rd;
      logic mem_wr;
      logic mem_lock;
      logic [63:0] mem_addr;
      logic [63:0] mem_wdata;
      logic mem_enclave;
      ecl_resp_type resp;
      logic done;
   } ecl_regs_type;

endpackage

// file: verification/ecl_engine_chk.sv
// Purpose: Port-level assertions for the hypervisor leaf engine.
// Assumes: Operands and maps hold still from the take until DONE.
// Notes:   Flag updates may land one cycle after DONE.
`timescale 1ns/1ps
`include "ecl_defs.svh"
module ecl_engine_chk #(
   parameter int CTX_OFFSET = `ECL_CTX_OFFSET,
   parameter int CNT_OFFSET = `ECL_CNT_OFFSET
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic REQ_VALID,
   input wire logic REQ_READY,
   input wire ecl_pkg::ecl_req_type REQ,
   input wire logic MEM_RD,
   input wire logic MEM_WR,
   input wire logic MEM_LOCK,
   input wire logic [63:0] MEM_WDATA,
   input wire logic MEM_ACK,
   input wire logic [63:0] MEM_RDATA,
   input wire logic DONE,
   input wire logic [1:0] FAULT,
   input wire ecl_pkg::ecl_resp_type RESP
);
   // ------------------------------------------------------------------
   // Leaf tracking
   // ------------------------------------------------------------------
   logic busy;
   logic wrote;
   logic [63:0] last_rd;
   logic take;
   logic inc;
   assign take = REQ_VALID && REQ_READY;
   assign inc = busy && (REQ.leaf == `ECL_LEAF_INC);
   always_ff @(posedge CLK) begin
      if (RST) begin
         busy <= 1'b0;
         wrote <= 1'b0;
         last_rd <= 64'h0;
      end else begin
         busy <= take || (busy && !DONE);
         wrote <= !take && (wrote || (MEM_WR && MEM_ACK));
         if (MEM_RD && MEM_ACK) begin
            last_rd <= MEM_RDATA;
         end
      end
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   property p_unaligned;
      take && REQ.leaf == `ECL_LEAF_INC && REQ.target[11:0] != 12'h0
         |-> ##[1:6] (DONE && FAULT == ecl_pkg::FLT_GP);
   endproperty
   a_unaligned: assert property (p_unaligned) else $error("Unaligned target not refused.");
   property p_bad_leaf;
      take && REQ.leaf != `ECL_LEAF_INC && REQ.leaf != `ECL_LEAF_SETCTX
         |-> ##[1:6] (DONE && FAULT == ecl_pkg::FLT_GP);
   endproperty
   a_bad_leaf: assert property (p_bad_leaf) else $error("Unknown leaf not refused.");
   property p_cpl;
      take && REQ.leaf == `ECL_LEAF_INC && REQ.cpl != 2'h0 |-> ##[1:6] (DONE && FAULT != 2'h0);
   endproperty
   a_cpl: assert property (p_cpl) else $error("Increment ran above level zero.");
   property p_result;
      DONE && FAULT == 2'h0
         |-> ##[0:1] (RESP.result == (RESP.zf ? `ECL_RES_CONFLICT : `ECL_RES_OK));
   endproperty
   a_result: assert property (p_result) else $error("Result code wrong.");
   property p_flags;
      DONE && FAULT == 2'h0 |-> ##[0:1] ({RESP.cf, RESP.pf, RESP.af, RESP.of_flag, RESP.sf} == 5'h0);
   endproperty
   a_flags: assert property (p_flags) else $error("Flags not cleared.");
   property p_keep;
      DONE && FAULT != 2'h0 |-> $stable(RESP) ##1 $stable(RESP);
   endproperty
   a_keep: assert property (p_keep) else $error("Fault changed the response.");
   property p_no_write;
      DONE && FAULT != 2'h0 |-> !wrote;
   endproperty
   a_no_write: assert property (p_no_write) else $error("Fault left a write.");
   property p_rmw;
      inc && MEM_RD && MEM_ACK |=> MEM_WR && MEM_LOCK && MEM_WDATA == last_rd + 64'h1;
   endproperty
   a_rmw: assert property (p_rmw) else $error("Counter update not locked plus one.");
   property p_ctx;
      busy && REQ.leaf == `ECL_LEAF_SETCTX && MEM_WR |-> MEM_WDATA == last_rd;
   endproperty
   a_ctx: assert property (p_ctx) else $error("Context not the fetched value.");
endmodule // ecl_engine_chk
bind ecl_engine ecl_engine_chk #(.CTX_OFFSET(CTX_OFFSET), .CNT_OFFSET(CNT_OFFSET)) u_chk (
   .CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ(REQ),
   .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_LOCK(MEM_LOCK), .MEM_WDATA(MEM_WDATA),
   .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .DONE(DONE), .FAULT(FAULT), .RESP(RESP)
);

// file: verification/enclave_child_count_context_leaves_bench.sv
// Purpose: Self-checking bench for the hypervisor leaf engine.
// Assumes: Memory answers after a random wait; maps hold still per leaf.
// Notes:   A scoreboard pairs each DONE with the oldest queued note.
`timescale 1ns/1ps
`include "ecl_defs.svh"
module enclave_child_count_context_leaves_bench;
   typedef struct packed {
      logic [1:0] f;
      logic [63:0] fa;
      logic [7:0] nw;
      logic [63:0] wd;
      logic [63:0] ra;
      logic [1:0] rl;
      logic [63:0] wa;
      ecl_pkg::ecl_resp_type r;
   } ecl_note_type;
   localparam logic [63:0] inc_lf = `ECL_LEAF_INC;
   localparam logic [63:0] set_lf = `ECL_LEAF_SETCTX;
   localparam logic [63:0] tgt = 64'h0000_0000_0020_0000;
   localparam logic [63:0] ctl = 64'h0000_0000_0010_0000;
   localparam logic [63:0] phy = 64'h0000_0000_8000_0000;
   localparam logic [63:0] dat = 64'h0000_0000_0030_0008;
   localparam logic [1:0] gp = 2'h1;
   localparam logic [1:0] pf = 2'h2;
   logic CLK, RST, REQ_VALID, REQ_READY, INIT_VALID, MEM_ACK, DONE, ak;
   logic MEM_RD, MEM_WR, MEM_LOCK, MEM_ENCLAVE;
   logic [63:0] INIT_PAGE, MEM_ADDR, MEM_WDATA, MEM_RDATA, FAULT_ADDR, rv, wd, ra, wa;
   logic [1:0] FAULT, rl;
   ecl_pkg::ecl_req_type REQ;
   ecl_pkg::ecl_map_type TARGET_MAP, CTRL_MAP, tok, cok;
   ecl_pkg::ecl_resp_type RESP, er;
   ecl_note_type q[$];
   ecl_note_type n;
   logic [2:0] kids[5] = '{`ECL_REGULAR_PAGE_TYPE, `ECL_THREAD_CONTROL_PAGE_TYPE, `ECL_TRIMMED_PAGE_TYPE, `ECL_FIRST_SHADOW_STACK_TYPE,
      `ECL_REST_SHADOW_STACK_TYPE};
   int bad_count, total_checks, nw, i, k;
   ecl_engine i_dut (
      .CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ(REQ),
      .TARGET_MAP(TARGET_MAP), .CTRL_MAP(CTRL_MAP), .INIT_VALID(INIT_VALID),
      .INIT_PAGE(INIT_PAGE), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_LOCK(MEM_LOCK),
      .MEM_ENCLAVE(MEM_ENCLAVE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
      .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .DONE(DONE), .FAULT(FAULT),
      .FAULT_ADDR(FAULT_ADDR), .RESP(RESP)
   );
   initial begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end
   // Between answers the read bus shows the inverse, so a stale capture shows up.
   always @(posedge CLK) begin
      ak = (MEM_RD === 1'b1 || MEM_WR === 1'b1) && MEM_ACK !== 1'b1 && $urandom_range(2) == 0;
      MEM_ACK <= ak;
      MEM_RDATA <= ak ? rv : ~rv;
   end
   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic wait_edge(input logic stop);
      @(posedge CLK);
      k++;
      if (k >= 40) begin
         bad_count++;
         give_verdict();
      end
   endtask
   function automatic ecl_pkg::ecl_map_type mk(logic [2:0] fl, logic [2:0] t,
         logic [63:0] ph, logic [63:0] pa);
      return {fl, t, ph, pa};
   endfunction
   task automatic lf(input logic [63:0] lv, tg, ct, dt, input logic [1:0] cl,
         input ecl_pkg::ecl_map_type tm, cm, input logic [1:0] f, input logic [63:0] fa);
      ecl_note_type e;
      rv = {$urandom, $urandom};
      e = '0;
      e.f = f;
      e.fa = fa;
      if (f == 2'h0) begin
         er = '0;
         if (lv == inc_lf ? tm.busy : cm.busy) begin
            er.zf = 1'b1;
            er.result = `ECL_RES_CONFLICT;
         end else begin
            e.nw = 8'h1;
            e.wd = lv == inc_lf ? rv + 64'h1 : rv;
            e.ra = lv == inc_lf ? cm.phys + `ECL_CNT_OFFSET : dt;
            e.rl = lv == inc_lf ? 2'h3 : 2'h0;
            e.wa = cm.phys + (lv == inc_lf ? `ECL_CNT_OFFSET : `ECL_CTX_OFFSET);
         end
      end
      e.r = er;
      q.push_back(e);
      @(posedge CLK);
      REQ_VALID <= 1'b1;
      {REQ.leaf, REQ.target, REQ.ctrl, REQ.data, REQ.cpl} <= {lv, tg, ct, dt, cl};
      TARGET_MAP <= tm;
      CTRL_MAP <= cm;
      k = 0;
      do wait_edge(1'b0); while (REQ_READY !== 1'b1);
      REQ_VALID <= 1'b0;
      k = 0;
      do wait_edge(1'b0); while (DONE !== 1'b1);
   endtask
   initial begin
      nw = 0;
      forever begin
         @(posedge CLK);
         if (MEM_RD === 1'b1 && MEM_ACK === 1'b1) begin
            ra = MEM_ADDR;
            rl = {MEM_ENCLAVE, MEM_LOCK};
         end
         if (MEM_WR === 1'b1 && MEM_ACK === 1'b1) begin
            nw++;
            wd = MEM_WDATA;
            wa = MEM_ADDR;
         end
         if (DONE === 1'b1) begin
            n = q.pop_front();
            chk(FAULT, n.f);
            if (n.f != 2'h0) chk(FAULT_ADDR, n.fa);
            chk(nw, n.nw);
            if (n.nw != 8'h0) chk({wa, wd}, {n.wa, n.wd});
            if (n.nw != 8'h0) chk({ra, rl}, {n.ra, n.rl});
            repeat (2) @(posedge CLK);
            chk(RESP, n.r);
            nw = 0;
         end
      end
   end
   initial begin
      i = $urandom(32'hB92A2346);
      {REQ_VALID, INIT_VALID, MEM_ACK, INIT_PAGE, MEM_RDATA, rv, er} = '0;
      RST = 1'b1;
      REQ = '0;
      {REQ.long_mode, REQ.seg_usable, REQ.seg_limit} = '1;
      {TARGET_MAP, CTRL_MAP} = '0;
      tok = mk(3'h6, `ECL_REGULAR_PAGE_TYPE, 64'h0, phy);
      cok = mk(3'h6, `ECL_PT_CTRL, phy, 64'h0);
      repeat (10) @(posedge CLK);
      RST <= 1'b0;
      foreach (kids[j]) lf(inc_lf, tgt, ctl, dat, 0, mk(3'h6, kids[j], 0, phy), cok, 0, 0);
      lf(inc_lf, tgt, ctl, dat, 0, mk(3'h6, `ECL_PT_CTRL, phy, 0), cok, 0, 0);
      lf(inc_lf, tgt, ctl, dat, 0, mk(3'h6, 3'h3, 0, phy), cok, pf, tgt);
      lf(inc_lf, tgt + 64'h8, ctl, dat, 0, tok, cok, gp, 0);
      lf(inc_lf, tgt, ctl, dat, 2'h3, tok, cok, gp, 0);
      lf(inc_lf, tgt, ctl, dat, 0, mk(3'h2, `ECL_REGULAR_PAGE_TYPE, 0, phy), cok, pf, tgt);
      lf(inc_lf, tgt, ctl, dat, 0, tok, mk(3'h2, `ECL_PT_CTRL, phy, 0), pf, ctl);
      lf(inc_lf, tgt, ctl, dat, 0, mk(3'h7, `ECL_REGULAR_PAGE_TYPE, 0, phy), cok, 0, 0);
      lf(inc_lf, tgt, ctl, dat, 0, mk(3'h4, `ECL_REGULAR_PAGE_TYPE, 0, phy), cok, pf, tgt);
      lf(inc_lf, tgt, ctl, dat, 0, mk(3'h6, `ECL_REGULAR_PAGE_TYPE, 0, ~phy), cok, gp, 0);
      lf(inc_lf, tgt, ctl, dat, 0, tok, mk(3'h7, `ECL_PT_CTRL, phy, 0), 0, 0);
      lf(inc_lf, tgt, ctl, dat, 0, tok, mk(3'h6, `ECL_REGULAR_PAGE_TYPE, phy, 0), pf, ctl);
      lf(inc_lf, 64'h0000_8000_0000_0000, ctl, dat, 0, tok, cok, gp, 0);
      {REQ.long_mode, REQ.seg_usable} <= 2'h0;
      lf(inc_lf, tgt, ctl, dat, 0, tok, cok, gp, 0);
      {REQ.seg_usable, REQ.seg_limit} <= {1'b1, 64'h0000_0000_0000_FFFF};
      lf(inc_lf, tgt, ctl, dat, 0, tok, cok, gp, 0);
      {REQ.long_mode, REQ.seg_limit} <= '1;
      lf(set_lf, 0, ctl, dat, 0, tok, cok, 0, 0);
      lf(set_lf, 0, ctl, dat, 0, tok, mk(3'h2, `ECL_PT_CTRL, phy, 0), pf, ctl);
      lf(set_lf, 0, ctl, dat + 64'h4, 0, tok, cok, gp, 0);
      lf(set_lf, 0, ctl + 64'h8, dat, 0, tok, cok, gp, 0);
      lf(set_lf, 0, ctl, dat, 0, tok, mk(3'h7, `ECL_PT_CTRL, phy, 0), 0, 0);
      lf(set_lf, 0, ctl, dat, 0, tok, mk(3'h6, `ECL_REGULAR_PAGE_TYPE, phy, 0), pf, ctl);
      lf(64'h3, tgt, ctl, dat, 0, tok, cok, gp, 0);
      INIT_PAGE <= ctl;
      INIT_VALID <= 1'b1;
      #1 chk(REQ_READY, 1'b0);
      @(posedge CLK);
      INIT_VALID <= 1'b0;
      k = 0;
      do wait_edge(1'b0); while (!(MEM_WR === 1'b1 && MEM_ACK === 1'b1));
      chk({MEM_ADDR, MEM_WDATA}, {ctl + `ECL_CTX_OFFSET, ctl});
      @(posedge CLK);
      nw = 0;
      for (i = 0; i < 20; i++) begin
         lf(inc_lf, tgt + {$urandom_range(255), 12'h0}, ctl, dat, 0, tok, cok, 0, 0);
      end
      repeat (4) @(posedge CLK);
      give_verdict();
   end
endmodule // enclave_child_count_context_leaves_bench
